/* File: nslpg_pkg.sv */
// Contract
// - Ready: triple green flash; pre-op 2: double; pre-op 1: single.
// - Basic Ethernet state drives bus-state LED with 10 Hz flicker.
// - Stopped state blinks bus-state LED 200 ms lit, 200 ms dark.
// - Flicker and blink light red and green alternately.
// - Bus-state LED dark while node initializes.
// - Bus-fault LED steady red while an error is present.
// - Bus-fault LED dark while no error is present.
// - Triple flash: three 200 ms flashes, 200 ms gaps, then 1000 ms dark.
// - Double flash: two 200 ms flashes, one 200 ms gap, then 1000 ms dark.
// - Single flash: one 200 ms flash, then 1000 ms dark, repeating.
// - State flicker: 50 ms lit, 50 ms dark.
// - Port LED steady green with link and no traffic.
// - Port LED flickers green with traffic, 50 ms lit and dark.
// - Low traffic toggles port LED per frame event, not fixed rate.
// - Port LED dark without link.
// - Yellow port LED always off.
`default_nettype none

package nslpg_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_MS = 1;
	localparam int MS_CNT_W = 11;

	localparam int FLASH_ON_MS = 200;
	localparam int FLASH_GAP_MS = 200;
	localparam int LONG_OFF_MS = 1000;
	localparam int FLICKER_MS = 50;
	localparam int BLINK_MS = 200;

	localparam logic [MS_CNT_W-1:0] FLASH_ON_TICKS = MS_CNT_W'(FLASH_ON_MS / TICK_MS);
	localparam logic [MS_CNT_W-1:0] FLASH_GAP_TICKS = MS_CNT_W'(FLASH_GAP_MS / TICK_MS);
	localparam logic [MS_CNT_W-1:0] LONG_OFF_TICKS = MS_CNT_W'(LONG_OFF_MS / TICK_MS);
	localparam logic [MS_CNT_W-1:0] FLICKER_TICKS = MS_CNT_W'(FLICKER_MS / TICK_MS);
	localparam logic [MS_CNT_W-1:0] BLINK_TICKS = MS_CNT_W'(BLINK_MS / TICK_MS);

	// ****************************************************************
	// Flash sequences
	// ****************************************************************
	localparam int PHASE_W = 3;
	localparam logic [PHASE_W-1:0] TRIPLE_LAST = 3'h5;
	localparam logic [PHASE_W-1:0] DOUBLE_LAST = 3'h3;
	localparam logic [PHASE_W-1:0] SINGLE_LAST = 3'h1;
	localparam logic [PHASE_W-1:0] TOGGLE_LAST = 3'h1;
	localparam logic [PHASE_W-1:0] PHASE_FIRST = 3'h0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [6:0] {
		NSLPG_NODE_INIT = 7'h01,
		NSLPG_NODE_STOPPED = 7'h02,
		NSLPG_NODE_BASIC_ETH = 7'h04,
		NSLPG_NODE_PREOP1 = 7'h08,
		NSLPG_NODE_PREOP2 = 7'h10,
		NSLPG_NODE_READY = 7'h20,
		NSLPG_NODE_OPER = 7'h40
	} nslpg_node_type;

	typedef enum logic [3:0] {
		NSLPG_PAT_DARK = 4'h1,
		NSLPG_PAT_STEADY = 4'h2,
		NSLPG_PAT_FLASH = 4'h4,
		NSLPG_PAT_TOGGLE = 4'h8
	} nslpg_pat_type;

	typedef enum logic [2:0] {
		NSLPG_ACT_IDLE = 3'h1,
		NSLPG_ACT_DARK = 3'h2,
		NSLPG_ACT_LIT = 3'h4
	} nslpg_act_type;

	typedef struct packed {
		logic red;
		logic green;
	} nslpg_duo_type;

	typedef struct packed {
		logic link;
		logic frame;
	} nslpg_port_in_type;

	typedef struct packed {
		logic green;
		logic yellow;
	} nslpg_port_led_type;

endpackage : nslpg_pkg

`default_nettype wire

/* File: nslpg_port_led.sv */
`default_nettype none

module nslpg_port_led
	import nslpg_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic tick_ms,
	input wire nslpg_port_in_type port_in,
	output nslpg_port_led_type port_led
);

	nslpg_act_type act_r;
	nslpg_act_type act_nxt;
	logic pending_r;
	logic consume;
	logic [MS_CNT_W-1:0] ms_cnt_r;
	logic phase_done;
	nslpg_port_led_type led_r;

	assign phase_done = tick_ms && (ms_cnt_r + 1'b1 >= FLICKER_TICKS);
	assign consume = (act_r == NSLPG_ACT_IDLE) && port_in.link && (pending_r || port_in.frame);

	// ****************************************************************
	// Frame event memory
	// ****************************************************************
	// Frames during a flicker buy exactly one more; a frame at idle starts one directly
	always_ff @(posedge core_clk) begin
		if (!reset_n || !port_in.link) begin
			pending_r <= 1'b0;
		end else if (port_in.frame && act_r != NSLPG_ACT_IDLE) begin
			pending_r <= 1'b1;
		end else if (consume) begin
			pending_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Activity flicker
	// ****************************************************************
	// Each frame burst buys one dark then one lit 50 ms phase; steady traffic
	// chains them into 10 Hz, sparse frames give irregular toggles
	always_comb begin
		act_nxt = act_r;
		case (act_r)
			NSLPG_ACT_IDLE: begin
				if (consume) act_nxt = NSLPG_ACT_DARK;
			end
			NSLPG_ACT_DARK: begin
				if (phase_done) act_nxt = NSLPG_ACT_LIT;
			end
			NSLPG_ACT_LIT: begin
				if (phase_done) act_nxt = NSLPG_ACT_IDLE;
			end
			default: act_nxt = NSLPG_ACT_IDLE;
		endcase
		if (!port_in.link) act_nxt = NSLPG_ACT_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			act_r <= NSLPG_ACT_IDLE;
		end else begin
			act_r <= act_nxt;
		end
	end

	// Phase timer restarts whenever the phase changes
	always_ff @(posedge core_clk) begin
		if (!reset_n || act_nxt != act_r) begin
			ms_cnt_r <= '0;
		end else if (tick_ms) begin
			ms_cnt_r <= ms_cnt_r + 1'b1;
		end
	end

	// ****************************************************************
	// LED drive
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			led_r <= '0;
		end else begin
			led_r.yellow <= 1'b0;
			led_r.green <= port_in.link && (act_r != NSLPG_ACT_DARK);
		end
	end

	assign port_led = led_r;

endmodule : nslpg_port_led

`default_nettype wire

/* File: nslpg_top.sv */
`default_nettype none

module nslpg_top
	import nslpg_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire nslpg_node_type node_state,
	input wire logic node_state_valid,
	input wire logic node_error,
	input wire nslpg_port_in_type ethernet_port_a_in,
	input wire nslpg_port_in_type ethernet_port_b_in,
	output nslpg_duo_type bus_state_led,
	output nslpg_duo_type bus_fault_led,
	output nslpg_port_led_type ethernet_port_a_led,
	output nslpg_port_led_type ethernet_port_b_led
);

	// Divider sized from the parameter, so simulation can shorten the tick while
	// every pattern length stays counted in ticks
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	// One activity engine per port on the card
	localparam int PORT_COUNT = 2;

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	// Divider count and its registered pulse
	logic [TICK_W-1:0] tick_cnt_r;
	logic tick_r;

	// Divider from core clock to one pulse per millisecond
	// Free running: a restart is not aligned to it, so the first phase after a
	// state change may be up to one tick short
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tick_cnt_r <= '0;
		end else if (tick_cnt_r == TICK_LAST) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	// Tick pulse is registered so every pattern sees it in the same cycle
	// The extra cycle of latency is invisible on an indicator
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == TICK_LAST);
		end
	end

	// ****************************************************************
	// Node state capture
	// ****************************************************************
	// Taken state, state being shown, and the difference between them
	nslpg_node_type node_r;
	nslpg_node_type shown_r;
	logic restart;

	// Held at initializing until firmware presents a valid state
	// A strobe keeps a settling state bus from restarting patterns on the way
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			node_r <= NSLPG_NODE_INIT;
		end else if (node_state_valid) begin
			node_r <= node_state;
		end
	end

	// Copy of the state the pattern engine is running for
	// One cycle behind node_r, so any difference marks a state change
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			shown_r <= NSLPG_NODE_INIT;
		end else begin
			shown_r <= node_r;
		end
	end

	// Rewriting the same state leaves the running pattern alone
	assign restart = (shown_r != node_r);

	// ****************************************************************
	// Pattern selection
	// ****************************************************************
	// Pattern kind, index of its last phase, and toggle phase length
	nslpg_pat_type pat_nxt;
	nslpg_pat_type pat_r;
	logic [PHASE_W-1:0] last_nxt;
	logic [PHASE_W-1:0] last_r;
	logic [MS_CNT_W-1:0] toggle_nxt;
	logic [MS_CNT_W-1:0] toggle_r;

	// Map the node state onto a pattern kind and its shape
	// Flash patterns share one engine and differ only in the index of the long
	// pause; toggle patterns have two equal phases of length toggle_nxt
	always_comb begin
		pat_nxt = NSLPG_PAT_DARK;
		last_nxt = PHASE_FIRST;
		toggle_nxt = FLICKER_TICKS;
		case (node_r)
			NSLPG_NODE_OPER: begin
				pat_nxt = NSLPG_PAT_STEADY;
			end
			// Flash family
			NSLPG_NODE_READY: begin
				pat_nxt = NSLPG_PAT_FLASH;
				last_nxt = TRIPLE_LAST;
			end
			NSLPG_NODE_PREOP2: begin
				pat_nxt = NSLPG_PAT_FLASH;
				last_nxt = DOUBLE_LAST;
			end
			NSLPG_NODE_PREOP1: begin
				pat_nxt = NSLPG_PAT_FLASH;
				last_nxt = SINGLE_LAST;
			end
			// Toggle family: flicker and blink differ only in phase length
			NSLPG_NODE_BASIC_ETH: begin
				pat_nxt = NSLPG_PAT_TOGGLE;
				last_nxt = TOGGLE_LAST;
				toggle_nxt = FLICKER_TICKS;
			end
			NSLPG_NODE_STOPPED: begin
				pat_nxt = NSLPG_PAT_TOGGLE;
				last_nxt = TOGGLE_LAST;
				toggle_nxt = BLINK_TICKS;
			end
			NSLPG_NODE_INIT: begin
				pat_nxt = NSLPG_PAT_DARK;
			end
			// Unknown codes fall back to dark rather than a misleading pattern
			default: begin
				pat_nxt = NSLPG_PAT_DARK;
			end
		endcase
	end

	// Pattern registers, loaded alongside the restart
	// They follow node_r every cycle; the restart resets the engine at the same edge
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pat_r <= NSLPG_PAT_DARK;
			last_r <= PHASE_FIRST;
			toggle_r <= FLICKER_TICKS;
		end else begin
			pat_r <= pat_nxt;
			last_r <= last_nxt;
			toggle_r <= toggle_nxt;
		end
	end

	// ****************************************************************
	// Phase engine
	// ****************************************************************
	// Phase index, elapsed ticks in the phase, and the colour of the current period
	logic [PHASE_W-1:0] phase_r;
	logic [MS_CNT_W-1:0] phase_ms_r;
	logic [MS_CNT_W-1:0] phase_len;
	logic phase_end;
	logic wrap;
	logic lit;
	logic colour_red_r;

	// Even phases are lit; the final odd phase of a flash is the long pause
	// Odd phases below the last one are the short gaps between flashes
	always_comb begin
		phase_len = FLASH_ON_TICKS;
		if (pat_r == NSLPG_PAT_TOGGLE) begin
			phase_len = toggle_r;
		end else if (phase_r[0] && phase_r == last_r) begin
			phase_len = LONG_OFF_TICKS;
		end else if (phase_r[0]) begin
			phase_len = FLASH_GAP_TICKS;
		end else begin
			phase_len = FLASH_ON_TICKS;
		end
	end

	// A phase ends on the tick that completes its length; wrap ends the sequence
	assign phase_end = tick_r && (phase_ms_r + 1'b1 >= phase_len);
	assign wrap = phase_end && (phase_r == last_r);
	assign lit = !phase_r[0];

	// Elapsed milliseconds inside the current phase
	// Cleared on restart so a new pattern counts its first phase from zero
	always_ff @(posedge core_clk) begin
		if (!reset_n || restart || phase_end) begin
			phase_ms_r <= '0;
		end else if (tick_r) begin
			phase_ms_r <= phase_ms_r + 1'b1;
		end
	end

	// Phase index; restart on a state change always begins lit
	// Phase 0 is lit for the flash and toggle patterns, so a restart is seen at once
	always_ff @(posedge core_clk) begin
		if (!reset_n || restart) begin
			phase_r <= PHASE_FIRST;
		end else if (wrap) begin
			phase_r <= PHASE_FIRST;
		end else if (phase_end) begin
			phase_r <= phase_r + 1'b1;
		end
	end

	// Colour swaps after each full on/off period so lit phases alternate
	// Flash patterns never swap, so for them the register stays at green
	always_ff @(posedge core_clk) begin
		if (!reset_n || restart) begin
			colour_red_r <= 1'b0;
		end else if (wrap && pat_r == NSLPG_PAT_TOGGLE) begin
			colour_red_r <= !colour_red_r;
		end
	end

	// ****************************************************************
	// Communication LED drive
	// ****************************************************************
	// Registered indicators; nothing reaches a pin without a flip-flop
	nslpg_duo_type state_led_r;
	nslpg_duo_type fault_led_r;

	// Restart cycle shows dark for one clock, invisible to an operator
	// The blank also keeps a phase of the old pattern from leaking into the new one
	always_ff @(posedge core_clk) begin
		if (!reset_n || restart) begin
			state_led_r <= '0;
		end else begin
			case (pat_r)
				NSLPG_PAT_STEADY: begin
					state_led_r.red <= 1'b0;
					state_led_r.green <= 1'b1;
				end
				NSLPG_PAT_FLASH: begin
					state_led_r.red <= 1'b0;
					state_led_r.green <= lit;
				end
				// One colour per lit phase, the other in the next period
				NSLPG_PAT_TOGGLE: begin
					state_led_r.red <= lit && colour_red_r;
					state_led_r.green <= lit && !colour_red_r;
				end
				NSLPG_PAT_DARK: begin
					state_led_r <= '0;
				end
				default: begin
					state_led_r <= '0;
				end
			endcase
		end
	end

	// Fault LED follows the error flag; the green element stays unused
	// No latch: clearing the flag in firmware darkens the LED one cycle later
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fault_led_r <= '0;
		end else begin
			fault_led_r.red <= node_error;
			fault_led_r.green <= 1'b0;
		end
	end

	// Outputs come straight from the flip-flops
	assign bus_state_led = state_led_r;
	assign bus_fault_led = fault_led_r;

	// ****************************************************************
	// Ethernet port LEDs
	// ****************************************************************
	nslpg_port_in_type port_in [PORT_COUNT];
	nslpg_port_led_type port_led [PORT_COUNT];

	// Array form so the engines come from one generate loop
	assign port_in[0] = ethernet_port_a_in;
	assign port_in[1] = ethernet_port_b_in;

	// One independent activity engine per port, sharing the tick
	// Each engine times its own flicker, so a busy port never disturbs a quiet one
	for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
		nslpg_port_led u_port_led (
			.core_clk(core_clk),
			.reset_n(reset_n),
			.tick_ms(tick_r),
			.port_in(port_in[p]),
			.port_led(port_led[p])
		);
	end

	// Back onto the named port outputs
	assign ethernet_port_a_led = port_led[0];
	assign ethernet_port_b_led = port_led[1];

endmodule : nslpg_top

`default_nettype wire

/* File: nslpg_asserts.sv */
`default_nettype none
// ****
// Indicator checker
// ****
module nslpg_asserts
	import nslpg_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire nslpg_node_type node_state,
	input wire logic node_state_valid,
	input wire logic node_error,
	input wire nslpg_port_in_type ethernet_port_a_in,
	input wire nslpg_port_in_type ethernet_port_b_in,
	input wire nslpg_duo_type bus_state_led,
	input wire nslpg_duo_type bus_fault_led,
	input wire nslpg_port_led_type ethernet_port_a_led,
	input wire nslpg_port_led_type ethernet_port_b_led
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Outputs are registered, so each is tied to its cause a fixed count of edges back
	property p_fault; $past(reset_n) |-> bus_fault_led == {$past(node_error), 1'b0}; endproperty
	a_fault: assert property (p_fault) else $error("fault led wrong");
	property p_yellow; !ethernet_port_a_led.yellow && !ethernet_port_b_led.yellow; endproperty
	a_yellow: assert property (p_yellow) else $error("yellow lit");
	property p_rst;
		$rose(reset_n) |-> {bus_state_led, bus_fault_led, ethernet_port_a_led} == 6'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("lit after reset");
	property p_link; !ethernet_port_a_in.link |=> !ethernet_port_a_led.green; endproperty
	a_link: assert property (p_link) else $error("port lit without link");
	property p_link_b; !ethernet_port_b_in.link |=> !ethernet_port_b_led.green; endproperty
	a_link_b: assert property (p_link_b) else $error("port b lit without link");
	property p_act;
		$fell(ethernet_port_a_led.green) && $past(ethernet_port_a_in.link)
			&& ethernet_port_a_in.link |-> !ethernet_port_a_led.green [*8];
	endproperty
	a_act: assert property (p_act) else $error("activity dark too short");
	property p_oper;
		node_state_valid && node_state == NSLPG_NODE_OPER ##1 !node_state_valid [*4]
			|-> bus_state_led == 2'h1;
	endproperty
	a_oper: assert property (p_oper) else $error("operational not green");
	property p_init;
		node_state_valid && node_state == NSLPG_NODE_INIT ##1 !node_state_valid [*4]
			|-> bus_state_led == 2'h0;
	endproperty
	a_init: assert property (p_init) else $error("initializing not dark");
	property p_duo; bus_state_led != 2'h3; endproperty
	a_duo: assert property (p_duo) else $error("both colours lit");
endmodule : nslpg_asserts

bind nslpg_top nslpg_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
	.core_clk(core_clk), .reset_n(reset_n), .node_state(node_state),
	.node_state_valid(node_state_valid), .node_error(node_error),
	.ethernet_port_a_in(ethernet_port_a_in), .ethernet_port_b_in(ethernet_port_b_in),
	.bus_state_led(bus_state_led), .bus_fault_led(bus_fault_led),
	.ethernet_port_a_led(ethernet_port_a_led), .ethernet_port_b_led(ethernet_port_b_led)
);
`default_nettype wire

/* File: nslpg_led_view.sv */
`default_nettype none
// ****
// Operator view of one duo indicator
// ****
module nslpg_led_view
	import nslpg_pkg::*;
(
	input wire logic core_clk,
	input wire nslpg_duo_type duo,
	output logic run_done,
	output nslpg_duo_type run_val,
	output int run_len
);
	timeunit 1ns;
	timeprecision 1ns;
	nslpg_duo_type last_r = 2'h0;
	int cnt_r = 0;

	// An eye sees runs of one colour; each ended run is reported with its length
	always_ff @(posedge core_clk) begin
		run_done <= duo !== last_r;
		if (duo !== last_r) begin
			run_val <= last_r;
			run_len <= cnt_r;
		end
		cnt_r <= (duo !== last_r) ? 1 : cnt_r + 1;
		last_r <= duo;
	end
endmodule : nslpg_led_view
`default_nettype wire

/* File: tb.sv */
`default_nettype none
// ****
// Indicator bench
// ****
module tb
	import nslpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TC = 4;
	localparam nslpg_duo_type G = 2'h1;
	localparam nslpg_duo_type R = 2'h2;
	localparam nslpg_duo_type D = 2'h0;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic valid = 1'b0;
	logic err = 1'b0;
	logic rd;
	nslpg_node_type st = NSLPG_NODE_INIT;
	nslpg_port_in_type pa = 2'h0;
	nslpg_port_in_type pb = 2'h0;
	nslpg_duo_type bs, bf, rv, rv_q[$], ev[$];
	nslpg_port_led_type la, lb;
	int rl, w, k, p, rl_q[$], el[$];
	int miscompares = 0;
	int num_checks = 0;
	int seed = 32'hed60aa9d;

	initial forever #10 core_clk = ~core_clk;

	nslpg_top #(.TICK_CYCLES(TC)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.node_state(st), .node_state_valid(valid), .node_error(err),
		.ethernet_port_a_in(pa), .ethernet_port_b_in(pb), .bus_state_led(bs),
		.bus_fault_led(bf), .ethernet_port_a_led(la), .ethernet_port_b_led(lb));
	nslpg_led_view u_view (.core_clk(core_clk), .duo(bs), .run_done(rd), .run_val(rv),
		.run_len(rl));

	// Collect the runs the operator saw
	always @(posedge core_clk) begin
		if (rd) begin
			rv_q.push_back(rv);
			rl_q.push_back(rl);
		end
	end

	task automatic chk_led(string what, logic [1:0] exp, logic [1:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk_led

	task automatic chk_len(string what, int lo, int hi, int got);
		num_checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
		end
	endtask : chk_len

	task automatic end_of_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic set_state(nslpg_node_type s);
		@(posedge core_clk);
		st <= s;
		valid <= 1'b1;
		@(posedge core_clk);
		valid <= 1'b0;
		#1;
		rv_q.delete();
		rl_q.delete();
	endtask : set_state

	// Old runs and the restart gap are short or dark, so they are dropped first
	task automatic run_pattern(nslpg_node_type pre, nslpg_node_type s);
		set_state(NSLPG_NODE_INIT);
		tick(4);
		if (pre != s)
			set_state(pre);
		set_state(s);
		for (w = 0; w < 40000 && rl_q.size() < el.size() + 5; w++)
			@(posedge core_clk);
		chk_len("pattern wait", 0, 39999, w);
		if (w == 40000)
			end_of_test();
		while (rv_q.size() > 0 && (rv_q[0] == D || rl_q[0] < 10 * TC)) begin
			void'(rv_q.pop_front());
			void'(rl_q.pop_front());
		end
		for (k = 0; k < el.size() + 2; k++) begin
			p = el[k % el.size()];
			chk_led("bs colour", ev[k % ev.size()], rv_q[k]);
			chk_len("bs phase", (p - 1) * TC, (p + 1) * TC, rl_q[k]);
		end
		$display("pattern %h done", s);
	endtask : run_pattern

	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		tick(1);
		chk_led("bs reset", D, bs);
		set_state(NSLPG_NODE_OPER);
		tick(300 * TC);
		chk_led("bs oper", G, bs);
		set_state(nslpg_node_type'(7'h03));
		tick(300 * TC);
		chk_led("bs bad code", D, bs);
		$display("steady done");
		ev = {G, D, G, D, G, D};
		el = {200, 200, 200, 200, 200, 1000};
		run_pattern(NSLPG_NODE_READY, NSLPG_NODE_READY);
		ev = {G, D};
		el = {200, 200, 200, 1000};
		run_pattern(NSLPG_NODE_PREOP1, NSLPG_NODE_PREOP2);
		el = {200, 1000};
		run_pattern(NSLPG_NODE_PREOP1, NSLPG_NODE_PREOP1);
		ev = {G, D, R, D};
		el = {50, 50, 50, 50};
		run_pattern(NSLPG_NODE_BASIC_ETH, NSLPG_NODE_BASIC_ETH);
		el = {200, 200, 200, 200};
		run_pattern(NSLPG_NODE_STOPPED, NSLPG_NODE_STOPPED);
		// Reset in mid pattern must fall back to initializing
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		tick(1);
		chk_led("bs in reset", D, bs);
		tick(100 * TC);
		chk_led("bs after reset", D, bs);
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			err <= 1'($random(seed));
			tick(1);
			chk_led("bf", {err, 1'b0}, bf);
		end
		$display("fault done");
		@(posedge core_clk);
		pa.link <= 1'b1;
		pb.link <= 1'b1;
		tick(5);
		chk_led("pa idle", 2'h2, la);
		chk_led("pb idle", 2'h2, lb);
		@(posedge core_clk);
		pa.frame <= 1'b1;
		@(posedge core_clk);
		pa.frame <= 1'b0;
		for (w = 0; w < 8 && la.green === 1'b1; w++)
			tick(1);
		for (w = 0; w < 100 * TC && la.green === 1'b0; w++)
			tick(1);
		chk_len("pa dark", 49 * TC, 51 * TC, w);
		for (w = 0; w < 150 * TC && la.green === 1'b1; w++)
			tick(1);
		chk_len("pa lit", 150 * TC, 150 * TC, w);
		chk_led("pa after frame", 2'h2, la);
		chk_led("pb quiet", 2'h2, lb);
		// Back-to-back frames must chain into an even flicker
		@(posedge core_clk);
		pa.frame <= 1'b1;
		for (w = 0; w < 8 && la.green === 1'b1; w++)
			tick(1);
		for (w = 0; w < 100 * TC && la.green === 1'b0; w++)
			tick(1);
		chk_len("pa busy dark", 49 * TC, 51 * TC, w);
		for (w = 0; w < 100 * TC && la.green === 1'b1; w++)
			tick(1);
		chk_len("pa busy lit", 49 * TC, 51 * TC, w);
		@(posedge core_clk);
		pa.frame <= 1'b0;
		pa.link <= 1'b0;
		pb.link <= 1'b0;
		tick(3);
		chk_led("pa no link", 2'h0, la);
		chk_led("pb no link", 2'h0, lb);
		$display("port done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
